// ==== hdl/spm_top.sv ====
// dual slot power management core with smbus target
`timescale 1ns/1ps
module spm_top
    import spm_pkg::*;
#(
    parameter int SLOTS = SPM_SLOTS
)
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // smbus
    input wire logic SMB_SCL,
    input wire logic SMB_SDA_IN,
    output logic SMB_SDA_OUT,
    output logic SMB_SDA_OE,
    output logic ALERT_N_OUT,
    output logic ALERT_N_OE,
    // straps and general inputs
    input wire logic [2:0] ADDR_STRAP,
    input wire logic [1:0] GENERAL_INPUT,
    // pin control path, active low override
    input wire logic [SLOTS-1:0] MAIN_ON_IN,
    input wire logic [SLOTS-1:0] AUX_ENABLE_IN,
    input wire logic [SLOTS-1:0] OVERRIDE_ON_N_IN,
    // analog monitor conditions
    input wire logic [SLOTS-1:0] MAIN_GOOD_IN,
    input wire logic [SLOTS-1:0] AUX_GOOD_IN,
    input wire logic [SLOTS-1:0] UV_IN,
    input wire logic STANDBY_UV_IN,
    input wire logic [SLOTS-1:0] OC12_IN,
    input wire logic [SLOTS-1:0] OC3_IN,
    input wire logic [SLOTS-1:0] OCAUX_IN,
    input wire logic [SLOTS-1:0] SLOT_HOT_IN,
    input wire logic DIE_HOT_IN,
    // slot outputs
    output logic [SLOTS-1:0] MAIN_EN_OUT,
    output logic [SLOTS-1:0] AUX_EN_OUT,
    output logic [SLOTS-1:0] POWER_GOOD_N_OUT,
    output logic [SLOTS-1:0] POWER_GOOD_N_OE,
    output logic [SLOTS-1:0] SLOT_FAULT_N_OUT,
    output logic [SLOTS-1:0] SLOT_FAULT_N_OE
);
    localparam int NS = 4 + 4 * SLOTS;
    logic [1:0] rst_sync;
    logic rst_n;
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];
    // three-stage synchronisers, change counts when stages 2 and 3 agree
    logic [NS-1:0] raw, s1, s2, s3, filt;
    // idle levels, so that no false edge follows reset
    localparam logic [NS-1:0] IN_IDLE = {2'h3, 2'h0, {(2 * SLOTS){1'b0}},
        {SLOTS{1'b1}}, {SLOTS{1'b0}}};
    assign raw = {SMB_SCL, SMB_SDA_IN, GENERAL_INPUT, MAIN_ON_IN,
        AUX_ENABLE_IN, OVERRIDE_ON_N_IN, UV_IN};
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= IN_IDLE;
            s2 <= IN_IDLE;
            s3 <= IN_IDLE;
            filt <= IN_IDLE;
        end else begin
            s1 <= raw;
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < NS; i++) begin
                if (s2[i] == s3[i]) begin
                    filt[i] <= s3[i];
                end
            end
        end
    end
    logic scl, sda;
    logic [1:0] general_input;
    logic [SLOTS-1:0] on_p, aux_p, ovr_n, uv;
    assign {scl, sda, general_input, on_p, aux_p, ovr_n, uv} = filt;
    // straps caught once after release of reset
    logic [2:0] strap_r;
    logic strap_done;
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            strap_r <= 3'h0;
            strap_done <= 1'b0;
        end else if (!strap_done) begin
            strap_r <= ADDR_STRAP;
            strap_done <= 1'b1;
        end
    end
    spm_if rbus();
    logic sda_oe;
    spm_smbus u_tgt (
        .clk(CLOCK),
        .rst_n(rst_n),
        .scl(scl),
        .sda(sda),
        .strap(strap_r),
        .sda_oe(sda_oe),
        .rb(rbus.tgt)
    );
    typedef struct packed {
        logic [SLOTS-1:0][2:0] ctl;
        logic [SLOTS-1:0][2:0] fbits;
        logic [1:0] shf;
        logic mask;
        logic [SLOTS-1:0] pfault;
        logic [SLOTS-1:0] pmain;
        logic [SLOTS-1:0] paux;
        logic [7:0] rdata;
        logic [SLOTS-1:0] main_en;
        logic [SLOTS-1:0] aux_en;
        logic [SLOTS-1:0] pg_oe;
        logic [SLOTS-1:0] flt_oe;
        logic alert_oe;
        logic sda_oe;
    } spm_core_t;
    spm_core_t c_r, c_nxt;
    function automatic logic sel(input logic [7:0] cmd, input logic [7:0] c);
        sel = (cmd == c);
    endfunction
    function automatic logic [7:0] slot_cmd(input logic [7:0] base,
        input int k);
        slot_cmd = base + k[7:0];
    endfunction
    logic [SLOTS-1:0] ovr, pin_mode, bus_mode;
    logic [SLOTS-1:0][2:0] fev;
    logic [1:0] shev;
    always_comb begin
        c_nxt = c_r;
        for (int k = 0; k < SLOTS; k++) begin
            ovr[k] = ~ovr_n[k] & ~c_r.ctl[k][CTL_GATE];
            pin_mode[k] = on_p[k] | aux_p[k];
            bus_mode[k] = c_r.ctl[k][CTL_MAIN] | c_r.ctl[k][CTL_AUX];
            fev[k][0] = bus_mode[k] & ~ovr[k] & (OC3_IN[k] | SLOT_HOT_IN[k]);
            fev[k][1] = bus_mode[k] & ~ovr[k] & (OC12_IN[k] | SLOT_HOT_IN[k]);
            fev[k][2] = bus_mode[k] & ~ovr[k] & (OCAUX_IN[k] | SLOT_HOT_IN[k]);
        end
        shev[0] = (|bus_mode) & (STANDBY_UV_IN | (|(uv & ~ovr)));
        shev[1] = (|bus_mode) & DIE_HOT_IN;
        // register writes, set wins over clear
        for (int k = 0; k < SLOTS; k++) begin
            if (rbus.wr && sel(rbus.cmd, slot_cmd(SPM_CMD_CTRL_A, k))) begin
                c_nxt.ctl[k] = rbus.wdata[2:0];
            end
            for (int b = 0; b < 3; b++) begin
                if (rbus.wr && sel(rbus.cmd, slot_cmd(SPM_CMD_STAT_A, k))
                    && rbus.wdata[2 * b]) begin
                    c_nxt.fbits[k][b] = 1'b0;
                end
                if (fev[k][b]) begin
                    c_nxt.fbits[k][b] = 1'b1;
                end
            end
            // pin path fault latch
            if (!on_p[k]) begin
                c_nxt.pmain[k] = 1'b0;
            end
            if (!aux_p[k]) begin
                c_nxt.paux[k] = 1'b0;
            end
            if (!ovr[k] && on_p[k] && (OC12_IN[k] | OC3_IN[k]
                | SLOT_HOT_IN[k] | DIE_HOT_IN | uv[k] | STANDBY_UV_IN)) begin
                c_nxt.pmain[k] = 1'b1;
            end
            if (!ovr[k] && aux_p[k] && (OCAUX_IN[k] | SLOT_HOT_IN[k]
                | DIE_HOT_IN | uv[k] | STANDBY_UV_IN)) begin
                c_nxt.paux[k] = 1'b1;
            end
            c_nxt.pfault[k] = c_nxt.pmain[k] | c_nxt.paux[k];
            // output enables
            c_nxt.main_en[k] = ~STANDBY_UV_IN & (ovr[k] |
                ((c_r.ctl[k][CTL_MAIN] | on_p[k]) & ~c_nxt.pmain[k]
                 & ~(|c_nxt.fbits[k][1:0]) & ~DIE_HOT_IN & ~uv[k]));
            c_nxt.aux_en[k] = ~STANDBY_UV_IN & (ovr[k] |
                ((c_r.ctl[k][CTL_AUX] | aux_p[k]) & ~c_nxt.paux[k]
                 & ~c_nxt.fbits[k][2] & ~DIE_HOT_IN & ~uv[k]));
            c_nxt.pg_oe[k] = ~ovr[k] & c_r.main_en[k] & c_r.aux_en[k]
                & MAIN_GOOD_IN[k] & AUX_GOOD_IN[k];
            c_nxt.flt_oe[k] = ~ovr[k] & pin_mode[k] & c_nxt.pfault[k];
        end
        for (int b = 0; b < 2; b++) begin
            if (rbus.wr && sel(rbus.cmd, SPM_CMD_SHARED)
                && rbus.wdata[SH_UV + b]) begin
                c_nxt.shf[b] = 1'b0;
            end
            if (shev[b]) begin
                c_nxt.shf[b] = 1'b1;
            end
        end
        if (rbus.wr && sel(rbus.cmd, SPM_CMD_SHARED)) begin
            c_nxt.mask = rbus.wdata[SH_MASK];
        end
        c_nxt.alert_oe = ~c_r.mask & ((|c_r.fbits) | (|c_r.shf));
        c_nxt.sda_oe = sda_oe;
        // read mux
        c_nxt.rdata = SPM_RESET_BYTE;
        for (int k = 0; k < SLOTS; k++) begin
            if (sel(rbus.cmd, slot_cmd(SPM_CMD_CTRL_A, k))) begin
                c_nxt.rdata[2:0] = c_r.ctl[k];
                c_nxt.rdata[CTL_MAIN_PG] = MAIN_GOOD_IN[k];
                c_nxt.rdata[CTL_AUX_PG] = AUX_GOOD_IN[k];
            end
            if (sel(rbus.cmd, slot_cmd(SPM_CMD_STAT_A, k))) begin
                c_nxt.rdata[ST_F3V] = c_r.fbits[k][0];
                c_nxt.rdata[ST_F12V] = c_r.fbits[k][1];
                c_nxt.rdata[ST_FAUX] = c_r.fbits[k][2];
                c_nxt.rdata[ST_AUX_ON] = c_r.aux_en[k];
                c_nxt.rdata[ST_MAIN_ON] = c_r.main_en[k];
                c_nxt.rdata[ST_FAULT] = c_r.pfault[k];
            end
        end
        if (sel(rbus.cmd, SPM_CMD_SHARED)) begin
            c_nxt.rdata[SH_UV] = c_r.shf[0];
            c_nxt.rdata[SH_OT] = c_r.shf[1];
            c_nxt.rdata[SH_MASK] = c_r.mask;
            c_nxt.rdata[SH_GPI0] = general_input[0];
            c_nxt.rdata[SH_GPI1] = general_input[1];
        end
    end
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            c_r <= '0;
        end else begin
            c_r <= c_nxt;
        end
    end
    assign rbus.rdata = c_r.rdata;
    assign SMB_SDA_OUT = 1'b0;
    assign SMB_SDA_OE = c_r.sda_oe;
    assign ALERT_N_OUT = 1'b0;
    assign ALERT_N_OE = c_r.alert_oe;
    assign MAIN_EN_OUT = c_r.main_en;
    assign AUX_EN_OUT = c_r.aux_en;
    assign POWER_GOOD_N_OUT = '0;
    assign POWER_GOOD_N_OE = c_r.pg_oe;
    assign SLOT_FAULT_N_OUT = '0;
    assign SLOT_FAULT_N_OE = c_r.flt_oe;
    a_mask_quiet: assert property (@(posedge CLOCK) disable iff (!rst_n)
        c_r.mask |=> !c_r.alert_oe)
        else $error("alert driven while masked");
    a_alert_on_fault: assert property (@(posedge CLOCK) disable iff (!rst_n)
        (!c_r.mask && (|c_r.fbits)) |=> c_r.alert_oe)
        else $error("alert missing on fault");
    a_fault_sticky: assert property (@(posedge CLOCK) disable iff (!rst_n)
        (c_r.fbits[0][0] && !(rbus.wr && rbus.cmd == SPM_CMD_STAT_A
         && rbus.wdata[ST_F3V])) |=> c_r.fbits[0][0])
        else $error("fault bit lost without clear");
    a_override_pins: assert property (@(posedge CLOCK) disable iff (!rst_n)
        ovr[0] |=> (!c_r.pg_oe[0] && !c_r.flt_oe[0] && c_r.main_en[0]
        || STANDBY_UV_IN))
        else $error("override did not release pins");
    a_bus_no_fault_pin: assert property (@(posedge CLOCK)
        disable iff (!rst_n)
        !pin_mode[0] |=> !c_r.flt_oe[0])
        else $error("fault pin in bus mode");
    a_pg_needs_enable: assert property (@(posedge CLOCK) disable iff (!rst_n)
        c_r.pg_oe[0] |-> $past(c_r.main_en[0]) && $past(c_r.aux_en[0]))
        else $error("power good without enable");
    a_pg_released: assert property (@(posedge CLOCK)
        disable iff (!rst_n)
        ovr[1] |=> !c_r.pg_oe[1])
        else $error("power good held in override");
    a_flt_released: assert property (@(posedge CLOCK)
        disable iff (!rst_n)
        ovr[1] |=> !c_r.flt_oe[1])
        else $error("fault pin held in override");
    a_override_on: assert property (@(posedge CLOCK)
        disable iff (!rst_n)
        (ovr[1] && !STANDBY_UV_IN) |=> (c_r.main_en[1] && c_r.aux_en[1]))
        else $error("override did not switch outputs on");
    a_standby_off: assert property (@(posedge CLOCK)
        disable iff (!rst_n)
        STANDBY_UV_IN |=> (!c_r.main_en[1] && !c_r.aux_en[1]))
        else $error("outputs on during standby lockout");
    a_gate_blocks: assert property (@(posedge CLOCK)
        disable iff (!rst_n)
        (c_r.ctl[1][CTL_GATE] && !on_p[1] && !c_r.ctl[1][CTL_MAIN])
        |=> !c_r.main_en[1]) else $error("gated override took effect");
    a_gpi_live: assert property (@(posedge CLOCK)
        disable iff (!rst_n)
        (rbus.cmd == SPM_CMD_SHARED) |=> c_r.rdata[SH_GPI0] == $past(general_input[0]))
        else $error("general input not read live");
    a_pin_fault: assert property (@(posedge CLOCK)
        disable iff (!rst_n)
        (c_r.pmain[1] && on_p[1] && !ovr[1]) |=> c_r.flt_oe[1])
        else $error("fault pin missing in pin control");
    a_main_latch: assert property (@(posedge CLOCK)
        disable iff (!rst_n)
        (c_r.pmain[1] && on_p[1]) |=> c_r.pmain[1])
        else $error("main fault lost while main pin high");
    a_pfault_clear: assert property (@(posedge CLOCK)
        disable iff (!rst_n)
        (!on_p[1] && !aux_p[1]) |=> !c_r.pfault[1])
        else $error("pin fault kept with enables low");
    a_shared_sticky: assert property (@(posedge CLOCK)
        disable iff (!rst_n)
        (c_r.shf[1] && !(rbus.wr && rbus.cmd == SPM_CMD_SHARED
         && rbus.wdata[SH_OT])) |=> c_r.shf[1]) else $error("shared bit lost");
    a_fault_set: assert property (@(posedge CLOCK)
        disable iff (!rst_n)
        (c_r.ctl[0][CTL_MAIN] && !ovr[0] && OC12_IN[0]) |=> c_r.fbits[0][1])
        else $error("overcurrent not recorded");
    a_alert_shared: assert property (@(posedge CLOCK)
        disable iff (!rst_n)
        (!c_r.mask && (|c_r.shf)) |=> c_r.alert_oe)
        else $error("alert missing on shared fault");
    a_alert_release: assert property (@(posedge CLOCK)
        disable iff (!rst_n)
        (!c_r.mask && !(|c_r.fbits) && !(|c_r.shf)) |=> !c_r.alert_oe)
        else $error("alert held with no fault");
endmodule

// ==== hdl/spm_pkg.sv ====
// package of constants and types for the slot power management block
package spm_pkg;
    localparam int SPM_SLOTS = 2;
    localparam logic [3:0] SPM_ADDR_HI = 4'h8;
    localparam logic [7:0] SPM_CMD_CTRL_A = 8'h02;
    localparam logic [7:0] SPM_CMD_CTRL_B = 8'h03;
    localparam logic [7:0] SPM_CMD_STAT_A = 8'h04;
    localparam logic [7:0] SPM_CMD_STAT_B = 8'h05;
    localparam logic [7:0] SPM_CMD_SHARED = 8'h06;
    localparam logic [7:0] SPM_CMD_LAST = 8'h07;
    localparam logic [7:0] SPM_RESET_BYTE = 8'h00;
    localparam logic [7:0] SPM_SHARED_RESET = 8'h00;
    // control register bits
    localparam int CTL_AUX = 0;
    localparam int CTL_MAIN = 1;
    localparam int CTL_GATE = 2;
    localparam int CTL_AUX_PG = 7;
    localparam int CTL_MAIN_PG = 6;
    // status register bits
    localparam int ST_F3V = 0;
    localparam int ST_F12V = 2;
    localparam int ST_FAUX = 4;
    localparam int ST_AUX_ON = 5;
    localparam int ST_MAIN_ON = 6;
    localparam int ST_FAULT = 7;
    // shared register bits
    localparam int SH_UV = 1;
    localparam int SH_OT = 2;
    localparam int SH_MASK = 3;
    localparam int SH_GPI0 = 4;
    localparam int SH_GPI1 = 5;
    localparam logic [7:0] SPM_STAT_W1C = 8'h15;
    localparam logic [7:0] SPM_SH_W1C = 8'h06;
    localparam logic [7:0] SPM_CTRL_WMASK = 8'h07;
    localparam logic [2:0] SPM_BIT_LAST = 3'h7;
    localparam logic [2:0] SPM_BIT_ZERO = 3'h0;
    typedef enum logic [6:0] {
        SPM_IDLE = 7'h01,
        SPM_ADDR = 7'h02,
        SPM_ACK = 7'h04,
        SPM_RX = 7'h08,
        SPM_TX = 7'h10,
        SPM_TACK = 7'h20,
        SPM_SKIP = 7'h40
    } spm_state_t;
endpackage

// ==== hdl/spm_if.sv ====
// interface between the bus target and the register core
`timescale 1ns/1ps
interface spm_if;
    logic wr;
    logic [7:0] cmd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport tgt (output wr, output cmd, output wdata, input rdata);
    modport core (input wr, input cmd, input wdata, output rdata);
endinterface

// ==== hdl/spm_smbus.sv ====
// smbus target: address match, byte write, byte read and receive byte
`timescale 1ns/1ps
module spm_smbus
    import spm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // filtered bus levels and latched address strap
    input wire logic scl,
    input wire logic sda,
    input wire logic [2:0] strap,
    // data line drive
    output logic sda_oe,
    // register access
    spm_if.tgt rb
);
    typedef struct packed {
        spm_state_t st;
        logic scl_d;
        logic sda_d;
        logic [7:0] sh;
        logic [2:0] cnt;
        logic rd;
        logic have_cmd;
        logic [7:0] ptr;
        logic wr;
        logic oe;
        logic full;
    } spm_tgt_t;
    spm_tgt_t s_r, s_nxt;
    wire rise = scl & ~s_r.scl_d;
    wire fall = ~scl & s_r.scl_d;
    wire start = scl & s_r.scl_d & s_r.sda_d & ~sda;
    wire stop = scl & s_r.scl_d & ~s_r.sda_d & sda;
    always_comb begin
        s_nxt = s_r;
        s_nxt.scl_d = scl;
        s_nxt.sda_d = sda;
        s_nxt.wr = 1'b0;
        if (stop) begin
            s_nxt.st = SPM_IDLE;
            s_nxt.oe = 1'b0;
        end else if (start) begin
            // repeated start keeps the latched pointer
            s_nxt.st = SPM_ADDR;
            s_nxt.cnt = SPM_BIT_ZERO;
            s_nxt.full = 1'b0;
            s_nxt.oe = 1'b0;
        end else begin
            case (s_r.st)
                SPM_IDLE: s_nxt.oe = 1'b0;
                SPM_ADDR, SPM_RX: begin
                    if (rise) begin
                        s_nxt.sh = {s_r.sh[6:0], sda};
                        s_nxt.cnt = s_r.cnt + 3'h1;
                        // eighth bit in, a wrapped count alone looks idle
                        s_nxt.full = (s_r.cnt == SPM_BIT_LAST);
                    end
                    if (fall && s_r.full) begin
                        s_nxt.full = 1'b0;
                        if (s_r.st == SPM_ADDR) begin
                            if (s_r.sh[7:1] == {SPM_ADDR_HI, strap}) begin
                                s_nxt.oe = 1'b1;
                                s_nxt.rd = s_r.sh[0];
                                s_nxt.have_cmd = 1'b0;
                                s_nxt.st = SPM_ACK;
                            end else begin
                                s_nxt.st = SPM_SKIP;
                            end
                        end else begin
                            s_nxt.oe = 1'b1;
                            s_nxt.st = SPM_ACK;
                            if (!s_r.have_cmd) begin
                                s_nxt.ptr = s_r.sh;
                                s_nxt.have_cmd = 1'b1;
                            end else begin
                                s_nxt.wr = 1'b1;
                            end
                        end
                    end
                end
                SPM_ACK: begin
                    if (fall) begin
                        s_nxt.cnt = SPM_BIT_ZERO;
                        if (s_r.rd) begin
                            s_nxt.sh = rb.rdata;
                            s_nxt.oe = ~rb.rdata[7];
                            s_nxt.st = SPM_TX;
                        end else begin
                            s_nxt.oe = 1'b0;
                            s_nxt.st = SPM_RX;
                        end
                    end
                end
                SPM_TX: begin
                    if (rise) begin
                        s_nxt.cnt = s_r.cnt + 3'h1;
                    end
                    if (fall) begin
                        if (s_r.cnt == SPM_BIT_ZERO) begin
                            s_nxt.oe = 1'b0;
                            s_nxt.st = SPM_TACK;
                        end else begin
                            s_nxt.sh = {s_r.sh[6:0], 1'b0};
                            s_nxt.oe = ~s_r.sh[6];
                        end
                    end
                end
                SPM_TACK: begin
                    if (rise) begin
                        // host ack asks for another byte, nack ends
                        s_nxt.st = sda ? SPM_SKIP : SPM_TACK;
                    end
                    if (fall && s_r.st == SPM_TACK && !s_nxt.sh[0]
                        && s_r.sda_d == 1'b0) begin
                        s_nxt.sh = rb.rdata;
                        s_nxt.oe = ~rb.rdata[7];
                        s_nxt.cnt = SPM_BIT_ZERO;
                        s_nxt.st = SPM_TX;
                    end
                end
                SPM_SKIP: s_nxt.oe = 1'b0;
                default: s_nxt.st = SPM_IDLE;
            endcase
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{st: SPM_IDLE, scl_d: 1'b1, sda_d: 1'b1,
                default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end
    assign sda_oe = s_r.oe;
    assign rb.wr = s_r.wr;
    assign rb.cmd = s_r.ptr;
    assign rb.wdata = s_r.sh;
    a_no_foreign_ack: assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.st == SPM_ADDR && fall && s_r.full
         && s_r.sh[7:1] != {SPM_ADDR_HI, strap} && !start && !stop)
        |=> !s_r.oe)
        else $error("acknowledged a foreign address");
    a_write_strobe: assert property (@(posedge clk) disable iff (!rst_n)
        s_r.wr |-> $past(s_r.st) == SPM_RX && $past(s_r.have_cmd))
        else $error("write strobe without command byte");
endmodule

// ==== tb/spm_host.sv ====
// smbus host model driving clock and data toward the target
`timescale 1ns/1ps
module spm_host #(
    parameter int Q = 5
)
(
    // clock
    input wire logic clk,
    // bus
    input wire logic sda_oe,
    output logic scl,
    output logic sda
);
    logic drv = 1'b1;
    // open drain data line with pull-up
    assign sda = drv & ~sda_oe;
    initial scl = 1'b1;
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic bit_io(input logic b, output logic s);
        drv <= b;
        tk(Q);
        scl <= 1'b1;
        tk(Q);
        @(negedge clk);
        s = sda;
        tk(Q);
        scl <= 1'b0;
        tk(Q);
    endtask
    task automatic start();
        drv <= 1'b1;
        tk(Q);
        scl <= 1'b1;
        tk(Q);
        drv <= 1'b0;
        tk(Q);
        scl <= 1'b0;
        tk(Q);
    endtask
    task automatic stop();
        drv <= 1'b0;
        tk(Q);
        scl <= 1'b1;
        tk(Q);
        drv <= 1'b1;
        tk(Q);
    endtask
    task automatic send(input logic [7:0] b, output logic nak);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, nak);
    endtask
    task automatic recv(output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, b[i]);
        end
        bit_io(1'b1, s);
    endtask
    // byte write, command byte sent as given with no range check
    task automatic wr(input logic [6:0] a, input logic [7:0] c, dt,
        output logic nak);
        logic n1;
        start();
        send({a, 1'b0}, nak);
        send(c, n1);
        send(dt, n1);
        stop();
    endtask
    // byte read with repeated start
    task automatic rd(input logic [6:0] a, input logic [7:0] c,
        output logic [7:0] dt);
        logic n1;
        start();
        send({a, 1'b0}, n1);
        send(c, n1);
        start();
        send({a, 1'b1}, n1);
        recv(dt);
        stop();
    endtask
    // receive byte from the latched pointer
    task automatic rv(input logic [6:0] a, output logic [7:0] dt);
        logic n1;
        start();
        send({a, 1'b1}, n1);
        recv(dt);
        stop();
    endtask
endmodule

// ==== tb/slot_power_mgmt_smbus_faults_test.sv ====
// self-checking bench for the slot power management core
`timescale 1ns/1ps
module slot_power_mgmt_smbus_faults_test;
    import spm_pkg::*;
    localparam logic [6:0] ME = {SPM_ADDR_HI, 3'h5};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic scl, sda, sda_oe, alert_oe;
    logic [1:0] general_input = 2'h2;
    logic [1:0] main_on = 2'h0, aux_on = 2'h0, ovr_n = 2'h3, uv = 2'h0;
    logic [1:0] m_good = 2'h0, a_good = 2'h0, oc12 = 2'h0, oc3 = 2'h0;
    logic die_hot = 1'b0;
    logic stby_uv = 1'b0;
    logic [1:0] hot = 2'h0;
    logic [1:0] main_en, aux_en, pg_oe, flt_oe;
    int n_fail = 0;
    int checks = 0;
    logic [7:0] d;
    logic nak;
    spm_top #(.SLOTS(2)) i_dut (
        .CLOCK(clk), .RST_N(rst_n), .SMB_SCL(scl), .SMB_SDA_IN(sda),
        .SMB_SDA_OUT(), .SMB_SDA_OE(sda_oe), .ALERT_N_OUT(),
        .ALERT_N_OE(alert_oe), .ADDR_STRAP(3'h5), .GENERAL_INPUT(general_input),
        .MAIN_ON_IN(main_on), .AUX_ENABLE_IN(aux_on),
        .OVERRIDE_ON_N_IN(ovr_n), .MAIN_GOOD_IN(m_good),
        .AUX_GOOD_IN(a_good), .UV_IN(uv), .STANDBY_UV_IN(stby_uv),
        .OC12_IN(oc12), .OC3_IN(oc3), .OCAUX_IN(2'h0),
        .SLOT_HOT_IN(hot), .DIE_HOT_IN(die_hot), .MAIN_EN_OUT(main_en),
        .AUX_EN_OUT(aux_en), .POWER_GOOD_N_OUT(),
        .POWER_GOOD_N_OE(pg_oe), .SLOT_FAULT_N_OUT(),
        .SLOT_FAULT_N_OE(flt_oe));
    spm_host i_host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [7:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d, failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic st();
        repeat (8) @(posedge clk);
    endtask
    task automatic t_regs();
        i_host.rd(ME, SPM_CMD_CTRL_A, d);
        check(d, SPM_RESET_BYTE);
        i_host.rd(ME, SPM_CMD_SHARED, d);
        check(d, 8'h20);
        general_input <= 2'h1;
        i_host.rd(ME, SPM_CMD_SHARED, d);
        check(d, 8'h10);
        i_host.rd(ME, SPM_CMD_LAST, d);
        check(d, 8'h00);
    endtask
    task automatic t_addr();
        i_host.wr(ME ^ 7'h01, SPM_CMD_CTRL_A, 8'h03, nak);
        check({7'h0, nak}, 8'h01);
        i_host.wr(7'h0C, SPM_CMD_CTRL_A, 8'h03, nak);
        check({7'h0, nak}, 8'h01);
        i_host.rd(ME, SPM_CMD_CTRL_A, d);
        check(d, SPM_RESET_BYTE);
    endtask
    task automatic t_ctrl();
        i_host.wr(ME, SPM_CMD_CTRL_A, 8'h03, nak);
        check({7'h0, nak}, 8'h00);
        m_good <= 2'h1;
        a_good <= 2'h1;
        st();
        check({4'h0, main_en, aux_en}, 8'h05);
        check({6'h0, pg_oe}, 8'h01);
        i_host.rd(ME, SPM_CMD_CTRL_A, d);
        check(d, 8'hC3);
        i_host.rv(ME, d);
        check(d, 8'hC3);
        check({6'h0, flt_oe}, 8'h00);
    endtask
    task automatic t_fault();
        oc12 <= 2'h1;
        st();
        oc12 <= 2'h0;
        st();
        check({7'h0, alert_oe}, 8'h01);
        i_host.wr(ME, SPM_CMD_STAT_A, 8'h00, nak);
        i_host.rd(ME, SPM_CMD_STAT_A, d);
        check(d & 8'h95, 8'h04);
        i_host.wr(ME, SPM_CMD_STAT_A, 8'h04, nak);
        st();
        check({7'h0, alert_oe}, 8'h00);
        i_host.rd(ME, SPM_CMD_STAT_A, d);
        check(d & 8'h95, 8'h00);
        hot <= 2'h1;
        st();
        hot <= 2'h0;
        i_host.rd(ME, SPM_CMD_STAT_A, d);
        check(d & 8'h15, 8'h15);
        i_host.wr(ME, SPM_CMD_STAT_A, 8'h15, nak);
        i_host.rd(ME, SPM_CMD_STAT_A, d);
        check(d & 8'h15, 8'h00);
    endtask
    task automatic t_mask();
        i_host.wr(ME, SPM_CMD_SHARED, 8'h08, nak);
        die_hot <= 1'b1;
        st();
        die_hot <= 1'b0;
        st();
        check({7'h0, alert_oe}, 8'h00);
        i_host.rd(ME, SPM_CMD_SHARED, d);
        check(d & 8'h0E, 8'h0C);
        i_host.wr(ME, SPM_CMD_SHARED, 8'h0C, nak);
        i_host.rd(ME, SPM_CMD_SHARED, d);
        check(d & 8'h0E, 8'h08);
    endtask
    task automatic t_pins();
        main_on <= 2'h2;
        aux_on <= 2'h2;
        m_good <= 2'h3;
        a_good <= 2'h3;
        st();
        check({7'h0, pg_oe[1]}, 8'h01);
        oc3 <= 2'h2;
        st();
        oc3 <= 2'h0;
        st();
        check({7'h0, flt_oe[1]}, 8'h01);
        ovr_n <= 2'h1;
        uv <= 2'h2;
        st();
        check({4'h0, main_en[1], aux_en[1], pg_oe[1], flt_oe[1]},
            8'h0C);
        stby_uv <= 1'b1;
        st();
        check({7'h0, main_en[1]}, 8'h00);
        stby_uv <= 1'b0;
        ovr_n <= 2'h3;
        uv <= 2'h0;
        st();
        main_on <= 2'h0;
        st();
        check({7'h0, flt_oe[1]}, 8'h00);
        i_host.wr(ME, SPM_CMD_CTRL_B, 8'h04, nak);
        ovr_n <= 2'h1;
        st();
        check({7'h0, main_en[1]}, 8'h00);
        ovr_n <= 2'h3;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        t_regs();
        t_addr();
        t_ctrl();
        t_fault();
        t_mask();
        t_pins();
        close_out();
    end
endmodule
